// *** shared/dsc_pkg.sv ***
/*
  Constants, field layouts and carrier types for the switch block
  configuration checker.
  Assumes a single 100 MHz clock and an AHB-Lite register slave.
*/
package dsc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DSC_OFF_STATUS  = 8'h00;
  localparam logic [7:0] DSC_OFF_CONFIG  = 8'h04;
  localparam logic [7:0] DSC_OFF_TIMEOUT = 8'h08;
  localparam logic [7:0] DSC_OFF_CTRL    = 8'h0C;

  // Status field positions
  localparam int ST_VALID    = 0;
  localparam int ST_CFG_ERR  = 1;
  localparam int ST_MODE_ERR = 2;
  localparam int ST_CHG_ERR  = 3;
  localparam int ST_ENABLE   = 4;
  localparam int ST_MODE_LSB = 8;

  // Control: bit 0 requests a fresh validation once switches are fixed
  localparam int CTRL_REVALIDATE = 0;

  // ----------------------------------------------------------------
  // Switch positions (bit index = switch number minus one)
  // ----------------------------------------------------------------
  localparam int SW_SENSORS  = 0;
  localparam int SW_MODE     = 1;
  localparam int SW_FEEDBACK = 2;
  localparam int SW_RESTART  = 3;
  localparam int SW_MENABLE  = 4;
  localparam int SW_EXTEND   = 5;
  localparam int SW_TO_A     = 6;
  localparam int SW_TO_B     = 7;

  // Switches 1..6 for the only permitted mode (on = 1)
  localparam logic [5:0] MODE7_PATTERN = 6'b01_1000;
  localparam logic [3:0] MODE7_NUMBER  = 4'h7;
  localparam logic [3:0] MODE_NONE     = 4'h0;

  // Timeout values in seconds
  localparam logic [31:0] TO_20S   = 32'h0000_0014;
  localparam logic [31:0] TO_2MIN  = 32'h0000_0078;
  localparam logic [31:0] TO_10MIN = 32'h0000_0258;
  localparam logic [31:0] TO_100H  = 32'h0005_7E40;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int SETTLE_US      = 10;
  localparam int SETTLE_CYCLES  = SETTLE_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DSC_ST_SETTLE  = 2'b00,
    DSC_ST_CHECK   = 2'b01,
    DSC_ST_RUN     = 2'b10,
    DSC_ST_FAULT   = 2'b11
  } dsc_state_t;

  typedef struct packed {
    logic        four_sensors;
    logic        sequence_mode;
    logic        feedback_mon;
    logic        manual_restart;
    logic        muting_enable;
    logic        timeout_ext;
    logic [1:0]  timeout_sel;
  } dsc_cfg_t;

  typedef struct packed {
    logic        cfg_err;
    logic        mode_err;
    logic        chg_err;
  } dsc_err_t;

endpackage : dsc_pkg

// *** hw/dsc_decode.sv ***
/*
  Combinational decoder of one switch word into configuration fields,
  timeout value and mode check.
  Assumes the word is already known equal in both blocks.
*/
`timescale 1ns/10ps
`default_nettype none
module dsc_decode
  import dsc_pkg::*;
(
  input  wire logic [7:0]  sw,
  output dsc_cfg_t         cfg,
  output logic [31:0]      timeout_s,
  output logic             mode_ok
);

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // On means set for every option switch
  assign cfg.four_sensors   = sw[SW_SENSORS];
  assign cfg.sequence_mode  = sw[SW_MODE];
  assign cfg.feedback_mon   = sw[SW_FEEDBACK];
  assign cfg.manual_restart = sw[SW_RESTART];
  assign cfg.muting_enable  = sw[SW_MENABLE];
  assign cfg.timeout_ext    = sw[SW_EXTEND];
  assign cfg.timeout_sel    = {sw[SW_TO_A], sw[SW_TO_B]};

  // Timeout table, switch 7 is the upper select bit
  always_comb begin
    case (cfg.timeout_sel)
      2'b00:   timeout_s = TO_20S;
      2'b01:   timeout_s = TO_2MIN;
      2'b10:   timeout_s = TO_10MIN;
      2'b11:   timeout_s = TO_100H;
      default: timeout_s = TO_20S;
    endcase
  end

  // Sequence muting is never accepted, it is outside the pattern
  assign mode_ok = (sw[5:0] == MODE7_PATTERN);

endmodule : dsc_decode
`default_nettype wire

// *** hw/dsc_checker.sv ***
/*
  Switch block configuration checker with AHB-Lite status registers.
  Samples both redundant switch blocks, validates at start-up and
  gates the safety output enable for the muting state machine.
  Assumes switch inputs are synchronous to hclk and the bus has this
  module as its only slave.
*/
`timescale 1ns/10ps
`default_nettype none
module dsc_checker
  import dsc_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  sw_block_a,
  input  wire logic [7:0]  sw_block_b,
  output dsc_cfg_t         cfg_out,
  output logic [31:0]      timeout_out,
  output logic             safety_output_en,
  output logic             config_valid,
  output dsc_err_t         err_out,
  output logic [3:0]       display_mode
);

  // ----------------------------------------------------------------
  // Decoder
  // ----------------------------------------------------------------
  dsc_cfg_t    dec_cfg;
  logic [31:0] dec_timeout;
  logic        dec_ok;

  dsc_decode u_decode (
    .sw        (sw_block_a),
    .cfg       (dec_cfg),
    .timeout_s (dec_timeout),
    .mode_ok   (dec_ok)
  );

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  dsc_state_t  state_r;
  dsc_state_t  state_nxt;
  logic [15:0] settle_r;
  logic [7:0]  snap_r;
  logic        blocks_differ;
  logic        changed;
  logic        reval_pulse;
  dsc_err_t    err_r;

  assign blocks_differ = (sw_block_a != sw_block_b);
  assign changed       = (sw_block_a != snap_r) || (sw_block_b != snap_r);

  // Next state: settle, check once, then run or latch a fault
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DSC_ST_SETTLE: begin
        if (settle_r == 16'(SETTLE - 1)) begin
          state_nxt = DSC_ST_CHECK;
        end
      end
      DSC_ST_CHECK: begin
        if (blocks_differ || !dec_ok) begin
          state_nxt = DSC_ST_FAULT;
        end else begin
          state_nxt = DSC_ST_RUN;
        end
      end
      DSC_ST_RUN: begin
        if (changed) begin
          state_nxt = DSC_ST_FAULT;
        end
      end
      DSC_ST_FAULT: begin
        // Only a deliberate request leaves the fault, never a switch flick
        if (reval_pulse) begin
          state_nxt = DSC_ST_SETTLE;
        end
      end
      default: state_nxt = DSC_ST_SETTLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= DSC_ST_SETTLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Settle counter gives switch contacts time before the check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_r <= 16'h0000;
    end else if (state_r == DSC_ST_SETTLE) begin
      settle_r <= settle_r + 16'h0001;
    end else begin
      settle_r <= 16'h0000;
    end
  end

  // Snapshot of the accepted word, compared while running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      snap_r <= 8'h00;
    end else if (state_r == DSC_ST_CHECK) begin
      snap_r <= sw_block_a;
    end
  end

  // Error flags latch on detection, cleared by a new validation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_r <= '0;
    end else if (state_r == DSC_ST_CHECK) begin
      err_r.cfg_err  <= blocks_differ;
      err_r.mode_err <= !dec_ok;
      err_r.chg_err  <= 1'b0;
    end else if (state_r == DSC_ST_RUN && changed) begin
      err_r.chg_err  <= 1'b1;
      err_r.cfg_err  <= err_r.cfg_err | blocks_differ;
    end
  end

  // Decoded outputs frozen at acceptance so a change cannot leak out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_out      <= '0;
      timeout_out  <= TO_20S;
      display_mode <= MODE_NONE;
    end else if (state_r == DSC_ST_CHECK && !blocks_differ && dec_ok) begin
      cfg_out      <= dec_cfg;
      timeout_out  <= dec_timeout;
      display_mode <= MODE7_NUMBER;
    end else if (state_nxt == DSC_ST_FAULT) begin
      display_mode <= MODE_NONE;
    end
  end

  // Enable only while running with an unchanged, matching word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      safety_output_en <= 1'b0;
      config_valid     <= 1'b0;
    end else begin
      safety_output_en <= (state_nxt == DSC_ST_RUN);
      config_valid     <= (state_nxt == DSC_ST_RUN);
    end
  end

  assign err_out = err_r;

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  logic       ap_valid;
  logic       dp_wr_r;
  logic       dp_rd_r;
  logic [7:0] dp_addr_r;

  assign ap_valid  = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r   <= 1'b0;
      dp_rd_r   <= 1'b0;
      dp_addr_r <= 8'h00;
    end else begin
      dp_wr_r   <= ap_valid && hwrite;
      dp_rd_r   <= ap_valid && !hwrite;
      dp_addr_r <= haddr[7:0];
    end
  end

  // Revalidation request is a one-cycle pulse from a control write
  assign reval_pulse = dp_wr_r && (dp_addr_r == DSC_OFF_CTRL) && hwdata[CTRL_REVALIDATE];

  // Read data registered at the address phase, unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      case (haddr[7:0])
        DSC_OFF_STATUS: begin
          hrdata <= 32'h0000_0000;
          hrdata[ST_VALID]    <= config_valid;
          hrdata[ST_CFG_ERR]  <= err_r.cfg_err;
          hrdata[ST_MODE_ERR] <= err_r.mode_err;
          hrdata[ST_CHG_ERR]  <= err_r.chg_err;
          hrdata[ST_ENABLE]   <= safety_output_en;
          hrdata[ST_MODE_LSB +: 4] <= display_mode;
        end
        DSC_OFF_CONFIG:  hrdata <= {24'h00_0000, cfg_out};
        DSC_OFF_TIMEOUT: hrdata <= timeout_out;
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_differ_off;
    @(posedge hclk) disable iff (!hresetn)
      (state_r == DSC_ST_CHECK && blocks_differ) |=> !safety_output_en && err_out.cfg_err;
  endproperty
  a_differ_off: assert property (p_differ_off) else $error("differing blocks kept enable");

  property p_timeout;
    @(posedge hclk) disable iff (!hresetn)
      (state_r == DSC_ST_CHECK && !blocks_differ && dec_ok && dec_cfg.timeout_sel == 2'b11)
      |=> timeout_out == TO_100H;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout decode wrong");

  property p_seq_refused;
    @(posedge hclk) disable iff (!hresetn)
      (state_r == DSC_ST_CHECK && sw_block_a[SW_MODE]) |=> err_out.mode_err;
  endproperty
  a_seq_refused: assert property (p_seq_refused) else $error("sequence mode accepted");

  property p_decode;
    @(posedge hclk) disable iff (!hresetn)
      $rose(config_valid) |-> cfg_out.manual_restart && cfg_out.muting_enable
                              && !cfg_out.four_sensors && !cfg_out.feedback_mon;
  endproperty
  a_decode: assert property (p_decode) else $error("accepted config not mode seven");

  property p_mode7;
    @(posedge hclk) disable iff (!hresetn)
      safety_output_en |-> snap_r[5:0] == MODE7_PATTERN;
  endproperty
  a_mode7: assert property (p_mode7) else $error("enable without mode seven");

  property p_mode_err;
    @(posedge hclk) disable iff (!hresetn)
      (state_r == DSC_ST_CHECK && !dec_ok) |=> !safety_output_en [*2];
  endproperty
  a_mode_err: assert property (p_mode_err) else $error("bad mode kept enable");

  property p_display;
    @(posedge hclk) disable iff (!hresetn)
      $rose(safety_output_en) |-> display_mode == MODE7_NUMBER;
  endproperty
  a_display: assert property (p_display) else $error("display not showing mode");

  property p_change;
    @(posedge hclk) disable iff (!hresetn)
      (state_r == DSC_ST_RUN && changed) |=> !safety_output_en && err_out.chg_err;
  endproperty
  a_change: assert property (p_change) else $error("switch change kept enable");

  property p_pending;
    @(posedge hclk) disable iff (!hresetn)
      (state_r == DSC_ST_SETTLE) |-> !safety_output_en;
  endproperty
  a_pending: assert property (p_pending) else $error("enable during validation");

endmodule : dsc_checker
`default_nettype wire

// *** testbench/dsc_partner.sv ***
/*
  Model of the muting state machine output stage behind the checker.
  Assumes enable and config come from the checker on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module dsc_partner
  import dsc_pkg::*;
(
  input  wire logic     hclk,
  input  wire logic     hresetn,
  input  wire logic     safety_output_en,
  input  wire dsc_cfg_t cfg_in,
  input  wire logic     restart_btn,
  output logic          safety_output_1,
  output logic          safety_output_2
);
  logic armed_r;

  // Interlock: manual restart waits for the button after each enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_r <= 1'b0;
    end else if (!safety_output_en) begin
      armed_r <= 1'b0;
    end else if (restart_btn || !cfg_in.manual_restart) begin
      armed_r <= 1'b1;
    end
  end

  // One gate for both channels, so no channel skew is modelled
  assign safety_output_1 = safety_output_en & armed_r;
  assign safety_output_2 = safety_output_en & armed_r;
endmodule : dsc_partner
`default_nettype wire

// *** testbench/tb.sv ***
/*
  Self-checking bench for the switch block configuration checker.
  Assumes one AHB-Lite slave and a shortened settle count.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dsc_pkg::*;
  localparam int SET = 4;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        restart_btn, en, cv, so1, so2;
  logic [31:0] haddr, hwdata, hrdata, rd, tmo;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  sw_a, sw_b, w, w2;
  logic [3:0]  disp;
  dsc_cfg_t    cfg;
  dsc_err_t    err;
  int          err_count, n_compared, i, k;

  assign hready = hreadyout;

  dsc_checker #(.SETTLE(SET)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sw_block_a(sw_a), .sw_block_b(sw_b), .cfg_out(cfg), .timeout_out(tmo),
    .safety_output_en(en), .config_valid(cv), .err_out(err), .display_mode(disp));

  dsc_partner u_partner (.hclk(hclk), .hresetn(hresetn), .safety_output_en(en),
    .cfg_in(cfg), .restart_btn(restart_btn), .safety_output_1(so1),
    .safety_output_2(so2));

  // ------------------------------------------------------------
  // Clock, expectations and shared tasks
  // ------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  function automatic logic [31:0] exp_to(input logic [7:0] s);
    case ({s[6], s[7]})
      2'b00:   return 32'h14;
      2'b01:   return 32'h78;
      2'b10:   return 32'h258;
      default: return 32'h57E40;
    endcase
  endfunction : exp_to

  // Field order is switch 1 first, matching the packed layout
  function automatic logic [7:0] exp_cfg(input logic [7:0] s);
    return {s[0], s[1], s[2], s[3], s[4], s[5], s[6], s[7]};
  endfunction : exp_cfg

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait, since hready is never assumed
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        $display("wrong value at %0t: bus hang", $time);
        tally_and_finish();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'b010;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : ahb

  // Power-up with fixed blocks; enable must stay low while settling
  task automatic start(input logic [7:0] a, input logic [7:0] b);
    @(posedge hclk);
    hresetn <= 1'b0;
    sw_a    <= a;
    sw_b    <= b;
    repeat (3) @(posedge hclk);
    #1 chk(en, 1'b0);
    // Release on the edge, like every other input
    @(posedge hclk) hresetn <= 1'b1;
    repeat (SET) @(posedge hclk);
    #1 chk(en, 1'b0);
    repeat (3) @(posedge hclk);
    #1;
  endtask : start

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; sw_a = 8'h00; sw_b = 8'h00; restart_btn = 1'b0;
    err_count = 0;
    n_compared = 0;
    void'($urandom(32'hEF2BBE30));
    // Accepted mode under every timeout code
    for (k = 0; k < 4; k++) begin
      w = {k[0], k[1], 6'b011000};
      start(w, w);
      chk(en, 1'b1);
      chk(disp, 4'h7);
      chk(tmo, exp_to(w));
      chk(cfg, exp_cfg(w));
      chk(so1, 1'b0);
      chk(cv, 1'b1);
      @(posedge hclk) restart_btn <= 1'b1;
      @(posedge hclk) restart_btn <= 1'b0;
      repeat (2) @(posedge hclk);
      #1 chk(so1 & so2, 1'b1);
      ahb(1'b0, {24'h0, DSC_OFF_STATUS}, 32'h0);
      chk(rd, 32'h711);
      chk(hresp, 1'b0);
      ahb(1'b0, {24'h0, DSC_OFF_CONFIG}, 32'h0);
      chk(rd, {24'h0, exp_cfg(w)});
      ahb(1'b0, {24'h0, DSC_OFF_TIMEOUT}, 32'h0);
      chk(rd, exp_to(w));
      $display("test mode7 timeout %0d done", k);
    end
    // Switch moved in operation
    @(posedge hclk) sw_b <= w ^ (8'h01 << $urandom_range(7));
    repeat (2) @(posedge hclk);
    #1 chk(en, 1'b0);
    chk(err.chg_err, 1'b1);
    chk(so1, 1'b0);
    $display("test change in operation done");
    // Blocks differ at power-up, then fixed and revalidated
    start(w, w ^ (8'h01 << $urandom_range(7)));
    chk(en, 1'b0);
    chk(err.cfg_err, 1'b1);
    @(posedge hclk) sw_b <= w;
    ahb(1'b1, {24'h0, DSC_OFF_CTRL}, 32'h1);
    repeat (SET + 3) @(posedge hclk);
    #1 chk(en, 1'b1);
    chk(err, 3'b000);
    $display("test block mismatch done");
    // Each single deviation from mode 7, then random words
    for (i = 0; i < 9; i++) begin
      w2 = (i < 6) ? (w ^ (8'h01 << i)) : 8'($urandom());
      if (w2[5:0] == 6'b011000) w2[0] = 1'b1;
      start(w2, w2);
      chk(en, 1'b0);
      chk(err.mode_err, 1'b1);
      chk(disp, 4'h0);
      chk(cv, 1'b0);
    end
    ahb(1'b0, {24'h0, DSC_OFF_STATUS}, 32'h0);
    chk(rd, 32'h4);
    ahb(1'b0, 32'h10, 32'h0);
    chk(rd, 32'h0);
    $display("test mode errors done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
